// File: logic/bpc_dead_time.sv
// Dead-time guard between the high-side and low-side gate drives.
module bpc_dead_time (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic want_hs,
    input wire logic want_ls,
    output logic gate_hs,
    output logic gate_ls
);
    import bpc_pkg::*;

    typedef struct packed {
        logic hs;
        logic ls;
        logic [3:0] gap;
    } bpc_dt_t;

    bpc_dt_t st_ff;
    bpc_dt_t nxt_st;

    // A switch may turn on only after both have been off for the full gap.
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.hs && !want_hs) begin
            nxt_st.hs = 1'b0;
            nxt_st.gap = 4'h0;
        end else if (st_ff.ls && !want_ls) begin
            nxt_st.ls = 1'b0;
            nxt_st.gap = 4'h0;
        end else if (!st_ff.hs && !st_ff.ls) begin
            if (st_ff.gap < DEAD_CNT) begin
                nxt_st.gap = st_ff.gap + 4'h1;
            end else if (want_hs && !want_ls) begin
                nxt_st.hs = 1'b1;
            end else if (want_ls && !want_hs) begin
                nxt_st.ls = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= '{hs: 1'b0, ls: 1'b0, gap: 4'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign gate_hs = st_ff.hs;
    assign gate_ls = st_ff.ls;

    never_both_a: assert property (@(posedge clk_sys) disable iff (rst)
        !(gate_hs && gate_ls)) else $error("Both switches on.");
    gap_before_on_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(gate_hs) |-> !$past(gate_ls, 1) && !$past(gate_ls, 5))
        else $error("High side on without dead time.");
endmodule : bpc_dead_time

// File: logic/bpc_pkg.sv
// Constants and types for the second regulator protection control.
package bpc_pkg;
    localparam int CLK_MHZ = 250;
    localparam int DEAD_NS = 20;
    // Least time, rounded up to whole cycles.
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] OVL_CYCLES = 3'h5;
    localparam logic [4:0] OFF_CYCLES = 5'h10;
    localparam int ERR_W = 8;
    localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;
    localparam logic [3:0] DEAD_CNT = 4'(DEAD_CYC);

    // Protection mode that shapes the switch request before the dead-time guard.
    typedef enum logic [1:0] {
        BPC_RUN = 2'b00,
        BPC_HOLD_LS = 2'b01,
        BPC_ALL_OFF = 2'b11
    } bpc_mode_t;
endpackage : bpc_pkg

// File: logic/bpc_top.sv
// Protection and supervision of the second step-down regulator.
module bpc_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cycle_start,
    input wire logic pwm_high,
    input wire logic hs_limit_pin,
    input wire logic ls_limit_pin,
    input wire logic ls_blank_done_pin,
    input wire logic overtemp_pin,
    input wire logic uvov_pin,
    input wire logic enable_clear,
    input wire logic enable_set,
    input wire logic fail_clear,
    output logic gate_hs,
    output logic gate_ls,
    output logic regulator_overtemp_flag,
    output logic regulator_fail_flag,
    output logic system_reset_out_n,
    output logic error_state,
    output logic [bpc_pkg::ERR_W-1:0] error_count,
    output logic second_regulator_enable,
    output logic sustained_overload
);
    import bpc_pkg::*;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [2:0] ovl;
        logic [4:0] off;
        bpc_mode_t mode;
        logic hs_cut;
        logic ls_cut;
        logic pwm_d;
        logic fresh_low;
        logic uvov_d;
        logic ot;
        logic fail;
        logic err;
        logic [ERR_W-1:0] cnt;
        logic en;
        logic ovl_hit;
    } bpc_st_t;

    bpc_st_t st_ff;
    bpc_st_t nxt_st;
    logic hs_lim;
    logic ls_lim;
    logic ls_blank;
    logic ot_in;
    logic uvov;
    logic uvov_rise;
    logic want_hs;
    logic want_ls;

    // Pins from the analog side pass a two-stage synchroniser first.
    assign hs_lim = st_ff.s2[0];
    assign ls_lim = st_ff.s2[1];
    assign ls_blank = st_ff.s2[2];
    assign ot_in = st_ff.s2[3];
    assign uvov = st_ff.s2[4];
    assign uvov_rise = uvov && !st_ff.uvov_d;

    // All protection decisions; cycle_start is the switching-cycle enable.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {uvov_pin, overtemp_pin, ls_blank_done_pin,
                     ls_limit_pin, hs_limit_pin};
        nxt_st.s2 = st_ff.s1;
        nxt_st.uvov_d = uvov;
        nxt_st.pwm_d = pwm_high;
        nxt_st.ovl_hit = 1'b0;
        // Set wins over clear for the sticky flags.
        if (ot_in) begin
            nxt_st.ot = 1'b1;
        end
        if (uvov_rise) begin
            nxt_st.fail = 1'b1;
            nxt_st.err = 1'b1;
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end else if (fail_clear) begin
            nxt_st.fail = 1'b0;
            nxt_st.ot = ot_in;
            nxt_st.err = 1'b0;
        end
        // Software clear disables; set re-enables, clear wins if both.
        if (enable_clear) begin
            nxt_st.en = 1'b0;
        end else if (enable_set) begin
            nxt_st.en = 1'b1;
        end
        if (st_ff.pwm_d && !pwm_high) begin
            nxt_st.fresh_low = 1'b1;
        end else if (pwm_high || (st_ff.fresh_low && ls_blank)) begin
            nxt_st.fresh_low = 1'b0;
        end
        if (st_ff.mode != BPC_RUN) begin
            // Forced-off period counts switching cycles.
            if (cycle_start) begin
                if (st_ff.off == OFF_CYCLES - 5'h01) begin
                    nxt_st.mode = BPC_RUN;
                    nxt_st.off = 5'h00;
                    nxt_st.ovl = 3'h0;
                    // Drop stale cuts so the period is sixteen cycles exactly.
                    nxt_st.hs_cut = 1'b0;
                    nxt_st.ls_cut = 1'b0;
                end else begin
                    nxt_st.off = st_ff.off + 5'h01;
                end
            end
        end else if (st_ff.fresh_low && ls_blank && ls_lim) begin
            nxt_st.mode = BPC_ALL_OFF;
            nxt_st.off = 5'h00;
            nxt_st.fresh_low = 1'b0;
        end else if (cycle_start) begin
            nxt_st.hs_cut = 1'b0;
            nxt_st.ls_cut = 1'b0;
            if (hs_lim) begin
                nxt_st.hs_cut = 1'b1;
                if (st_ff.ovl == OVL_CYCLES - 3'h1) begin
                    nxt_st.mode = BPC_HOLD_LS;
                    nxt_st.ovl_hit = 1'b1;
                    nxt_st.off = 5'h00;
                    nxt_st.ovl = 3'h0;
                end else begin
                    nxt_st.ovl = st_ff.ovl + 3'h1;
                end
            end else begin
                nxt_st.ovl = 3'h0;
            end
        end else begin
            if (hs_lim) begin
                nxt_st.hs_cut = 1'b1;
            end
            if (ls_lim) begin
                nxt_st.ls_cut = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= '{mode: BPC_RUN, cnt: ERR_RESET, en: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Requested drives; the high-side cut also forces the low side on unless the low side has its own cut.
    always_comb begin
        want_hs = 1'b0;
        want_ls = 1'b0;
        if (st_ff.en && st_ff.mode == BPC_RUN) begin
            want_hs = pwm_high && !st_ff.hs_cut;
            want_ls = (!pwm_high || st_ff.hs_cut) && !st_ff.ls_cut;
        end else if (st_ff.en && st_ff.mode == BPC_HOLD_LS) begin
            want_ls = 1'b1;
        end
    end

    bpc_dead_time u_dead (
        .clk_sys(clk_sys),
        .rst(rst),
        .want_hs(want_hs),
        .want_ls(want_ls),
        .gate_hs(gate_hs),
        .gate_ls(gate_ls)
    );

    assign regulator_overtemp_flag = st_ff.ot;
    assign regulator_fail_flag = st_ff.fail;
    assign system_reset_out_n = !st_ff.err;
    assign error_state = st_ff.err;
    assign error_count = st_ff.cnt;
    assign second_regulator_enable = st_ff.en;
    assign sustained_overload = st_ff.ovl_hit;

    sequence uvov_edge_s;
        uvov_rise;
    endsequence
    sequence fault_shown_s;
        regulator_fail_flag && !system_reset_out_n && error_state;
    endsequence

    uvov_reaction_a: assert property (@(posedge clk_sys) disable iff (rst)
        uvov_edge_s |=> fault_shown_s)
        else $error("Voltage fault not reported.");
    count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
        uvov_rise |=> error_count == $past(error_count) + 8'h01)
        else $error("Error count did not step.");
    overtemp_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        ot_in |=> regulator_overtemp_flag)
        else $error("Overtemp flag not set.");
    hold_ls_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_ff.mode == BPC_HOLD_LS |-> !want_hs)
        else $error("High side requested in overload.");
    all_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_ff.mode == BPC_ALL_OFF |-> !want_hs && !want_ls)
        else $error("Switch requested in all-off.");
    hs_cut_ls_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_ff.en && st_ff.mode == BPC_RUN && st_ff.hs_cut && !st_ff.ls_cut
        |-> want_ls && !want_hs)
        else $error("High-side cut without low side.");
    ls_cut_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_ff.ls_cut |-> !want_ls)
        else $error("Low side on after its limit.");
    ovl_count_a: assert property (@(posedge clk_sys) disable iff (rst)
        cycle_start && st_ff.mode == BPC_RUN && !hs_lim && !(st_ff.fresh_low
        && ls_blank && ls_lim) |=> st_ff.ovl == 3'h0)
        else $error("Overload count not cleared.");
    overload_enter_a: assert property (@(posedge clk_sys) disable iff (rst)
        sustained_overload |-> st_ff.mode == BPC_HOLD_LS)
        else $error("Overload pulse without hold.");
    disabled_a: assert property (@(posedge clk_sys) disable iff (rst)
        !second_regulator_enable |-> !want_hs && !want_ls)
        else $error("Drive while disabled.");
endmodule : bpc_top

// File: sim/bpc_bridge_model.sv
// Half-bridge stand-in with its two current comparators.
module bpc_bridge_model (
    input wire logic clk_sys,
    input wire logic gate_ls,
    input wire logic short_gnd,
    input wire logic short_sup,
    output logic hs_limit_pin,
    output logic ls_limit_pin,
    output logic ls_blank_done_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] blank_ff = 2'h0;
    // A hard short keeps the high-side current over its limit all cycle.
    assign hs_limit_pin = short_gnd;
    // The low-side comparator can only trip while that switch conducts.
    assign ls_limit_pin = short_sup & gate_ls;
    // Blanking masks the switching spike for two clocks after turn-on.
    always @(posedge clk_sys) begin
        blank_ff <= gate_ls ? {blank_ff[0], 1'b1} : 2'h0;
    end
    assign ls_blank_done_pin = blank_ff[1];
endmodule : bpc_bridge_model

// File: sim/tb_bpc_top.sv
// Self-checking bench for the regulator protection control.
module tb_bpc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bpc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cycle_start = 1'b0;
    logic pwm_high = 1'b0;
    logic overtemp_pin = 1'b0;
    logic uvov_pin = 1'b0;
    logic en_clr = 1'b0;
    logic en_set = 1'b0;
    logic fail_clear = 1'b0;
    logic short_gnd = 1'b0;
    logic short_sup = 1'b0;
    logic run = 1'b0;
    logic [4:0] phase = 5'h00;
    logic hs_lim, ls_lim, ls_done, g_hs, g_ls, ot, fail, sys_rst_n;
    logic err_st, ovl, en;
    logic [ERR_W-1:0] err_cnt;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int k;

    bpc_top dut (.clk_sys(clk_sys), .rst(rst), .cycle_start(cycle_start),
        .pwm_high(pwm_high), .hs_limit_pin(hs_lim), .ls_limit_pin(ls_lim),
        .ls_blank_done_pin(ls_done), .overtemp_pin(overtemp_pin),
        .uvov_pin(uvov_pin), .enable_clear(en_clr), .enable_set(en_set),
        .fail_clear(fail_clear), .gate_hs(g_hs), .gate_ls(g_ls),
        .regulator_overtemp_flag(ot), .regulator_fail_flag(fail),
        .system_reset_out_n(sys_rst_n), .error_state(err_st),
        .error_count(err_cnt), .second_regulator_enable(en),
        .sustained_overload(ovl));
    bpc_bridge_model bridge (.clk_sys(clk_sys), .gate_ls(g_ls),
        .short_gnd(short_gnd), .short_sup(short_sup), .hs_limit_pin(hs_lim),
        .ls_limit_pin(ls_lim), .ls_blank_done_pin(ls_done));

    always #2 clk_sys = ~clk_sys;

    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task complete_run();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    task to_phase(input logic [4:0] p);
        do @(negedge clk_sys); while (phase != p);
    endtask : to_phase

    // A 32-clock switching cycle leaves room for the dead time each way.
    always @(negedge clk_sys) begin
        phase <= phase + 5'h01;
        cycle_start <= run && phase == 5'h1F;
        pwm_high <= run && (phase == 5'h1F || phase < 5'h0F);
        cyc <= cyc + 1;
        if (!rst) check({7'h00, g_hs & g_ls}, 8'h00);
        if (cyc == 12000) begin
            err_count++;
            complete_run();
        end
    end

    task t_faults();
        overtemp_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({7'h00, ot}, 8'h01);
        overtemp_pin = 1'b0;
        for (k = 1; k < 3; k++) begin
            uvov_pin = 1'b1;
            repeat (4) @(negedge clk_sys);
            check({5'h00, fail, sys_rst_n, err_st}, 8'h05);
            check(err_cnt, 8'(k));
            uvov_pin = 1'b0;
            repeat (3) @(negedge clk_sys);
            fail_clear = 1'b1;
            @(negedge clk_sys);
            fail_clear = 1'b0;
            repeat (2) @(negedge clk_sys);
            check({5'h00, fail, sys_rst_n, ot}, 8'h02);
        end
    endtask : t_faults

    // Four shorted starts, one clean, four more: the count must restart.
    task t_count_clear();
        run = 1'b1;
        to_phase(5'h04);
        k = 0;
        for (int i = 0; i < 9; i++) begin
            short_gnd = (i != 4);
            to_phase(5'h0E);
            // The cut taken at a shorted start lasts to the end of the cycle.
            check({6'h00, g_hs, g_ls}, 8'h01);
            if (ovl === 1'b1) k = 1;
            to_phase(5'h04);
        end
        check(8'(k), 8'h00);
    endtask : t_count_clear

    task t_overload();
        for (k = 0; k < 300 && ovl !== 1'b1; k++) @(negedge clk_sys);
        check({7'h00, ovl}, 8'h01);
        short_gnd = 1'b0;
        repeat (14 * 32) begin
            @(negedge clk_sys);
            check({7'h00, g_hs}, 8'h00);
        end
        check({7'h00, g_ls}, 8'h01);
        for (k = 0; k < 120 && g_hs !== 1'b1; k++) @(negedge clk_sys);
        check({7'h00, g_hs}, 8'h01);
    endtask : t_overload

    task t_ls_short();
        to_phase(5'h0A);
        short_sup = 1'b1;
        for (k = 0; k < 64 && g_ls !== 1'b1; k++) @(negedge clk_sys);
        repeat (8) @(negedge clk_sys);
        short_sup = 1'b0;
        repeat (14 * 32) begin
            @(negedge clk_sys);
            check({6'h00, g_hs, g_ls}, 8'h00);
        end
        for (k = 0; k < 120 && g_hs !== 1'b1; k++) @(negedge clk_sys);
        check({7'h00, g_hs}, 8'h01);
    endtask : t_ls_short

    task t_enable();
        en_clr = 1'b1;
        @(negedge clk_sys);
        en_clr = 1'b0;
        repeat (64) begin
            @(negedge clk_sys);
            check({6'h00, g_hs, g_ls, en}, 8'h00);
        end
        en_set = 1'b1;
        @(negedge clk_sys);
        en_set = 1'b0;
        @(negedge clk_sys);
        check({7'h00, en}, 8'h01);
    endtask : t_enable

    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        check({5'h00, en, sys_rst_n, fail}, 8'h06);
        check(err_cnt, ERR_RESET);
        t_faults();
        t_count_clear();
        t_overload();
        t_ls_short();
        t_enable();
        complete_run();
    end
endmodule : tb_bpc_top
